/* core/otat_top.sv */
// Overtemperature line assertion timer, alert and pin function control.
// Assumes an upstream serial-bus engine delivering one-cycle register
// strobes, and a fan controller that supplies per-fan duty and mode.
// Operation
// RQ1: Masking a source hides only its alert; its status bit still sets.
// RQ2: Config three bit 0 makes fan-drive pin two the alert output.
// RQ3: Config four bits 1:0 pick tach input, overtemp line, alert, reserved.
// RQ4: Overtemp enable chooses dedicated pin role and enables multi-pin line.
// RQ5: Timer monitoring enable comes out of reset disabled.
// RQ6: Full_speed_on_overtemp bit drives running fans to full duty while the line is low.
// RQ7: Full_speed_on_overtemp only touches fans already running by duty or temperature.
// RQ8: Full_speed_on_overtemp clear leaves fan duties untouched by line assertions.
// RQ9: Timer counts only during assertion, pausing and resuming cumulatively.
// RQ10: Timer saturates at full scale until cleared.
// RQ11: Reading the timer register clears it.
// RQ12: Bit 0 sets on first assertion; later counts are 22.76 ms each.
// RQ13: Read during assertion clears, sets bit 0, then counts from zero.
// RQ14: Read during assertion with zero limit sets the overtemp status flag.
// RQ15: Timer above limit sets status two bit 5 and raises alert.
// RQ16: Limit zero alerts on first assertion, one after 45.52 ms.
// RQ17: Mask two bit 5 or mask one bit 0 hides the alert by pin.
// RQ18: Host clears status two bit 5 after reading an exceeded timer.
// RQ19: Host keeps the timer mask bit clear to receive alerts.
// RQ20: Status bits are sticky, cleared by a read once the cause ends.
// RQ21: Alert stays low while out of limit and until status is read.
// RQ22: Alert is active-low open drain for any unmasked set status bit.
`timescale 1ns/10ps
module otat_top #(
  parameter int TICK_CYCLES = otat_pkg::TICK_CYCLES,
  parameter int NUM_FANS    = 3
) (
  input  wire logic                   CLK,
  input  wire logic                   RST,
  input  otat_pkg::otat_reg_req_s     REG_REQ,
  output logic                        REG_RVALID,
  output logic [7:0]                  REG_RDATA,
  input  wire logic                   OVERTEMP_LINE_N_IN,
  input  wire logic                   MULTI_PIN_IN,
  output logic                        MULTI_PIN_OUT,
  output logic                        MULTI_PIN_OE,
  output logic                        FAN2_PIN_OUT,
  output logic                        FAN2_PIN_OE,
  input  wire logic                   FAN_DRIVE_OUTPUT_2,
  output logic                        FAN_SPEED_INPUT_4,
  output logic                        VIN25_MEASURE_EN,
  input  otat_pkg::otat_fan_s [NUM_FANS-1:0] FAN_IN,
  output logic [NUM_FANS-1:0][7:0]    FAN_DUTY_OUT
);

  logic [7:0] cfg3_q;
  logic [7:0] cfg4_q;
  logic [7:0] limit_q;
  logic [7:0] mask1_q;
  logic [7:0] mask2_q;
  logic       ot_status_q;
  logic       ot_status_d;
  logic [7:0] timer_val;
  logic [1:0] pins_sync;
  logic       ded_line_n;
  logic       multi_line_n;

  // Pin levels from outside pass two flip-flops before any logic.
  // Both pins share one synchroniser so that they see the same latency;
  // a pulse shorter than two clocks may be lost.
  otat_sync #(
    .W        (2)
  ) u_sync (
    .clk      (CLK),
    .rst      (RST),
    .async_in ({MULTI_PIN_IN, OVERTEMP_LINE_N_IN}),
    .sync_out (pins_sync)
  );

  assign ded_line_n   = pins_sync[0];
  assign multi_line_n = pins_sync[1];

  // Address match, shared by the write strobes and the read selector.
  function automatic logic addr_is(logic [7:0] addr, logic [7:0] reg_addr);
    return (addr == reg_addr);
  endfunction

  logic hit_cfg3;
  logic hit_cfg4;
  logic hit_limit;
  logic hit_mask1;
  logic hit_mask2;
  logic hit_timer;
  logic hit_status2;

  assign hit_cfg3    = addr_is(REG_REQ.addr, otat_pkg::ADDR_CFG3);
  assign hit_cfg4    = addr_is(REG_REQ.addr, otat_pkg::ADDR_CFG4);
  assign hit_limit   = addr_is(REG_REQ.addr, otat_pkg::ADDR_LIMIT);
  assign hit_mask1   = addr_is(REG_REQ.addr, otat_pkg::ADDR_MASK1);
  assign hit_mask2   = addr_is(REG_REQ.addr, otat_pkg::ADDR_MASK2);
  assign hit_timer   = addr_is(REG_REQ.addr, otat_pkg::ADDR_TIMER);
  assign hit_status2 = addr_is(REG_REQ.addr, otat_pkg::ADDR_STATUS2);

  // Register access decoding.
  logic wr_cfg3;
  logic wr_cfg4;
  logic wr_limit;
  logic wr_mask1;
  logic wr_mask2;
  logic rd_timer;
  logic rd_status2;

  assign wr_cfg3    = REG_REQ.wr && hit_cfg3;
  assign wr_cfg4    = REG_REQ.wr && hit_cfg4;
  assign wr_limit   = REG_REQ.wr && hit_limit;
  assign wr_mask1   = REG_REQ.wr && hit_mask1;
  assign wr_mask2   = REG_REQ.wr && hit_mask2;
  assign rd_timer   = REG_REQ.rd && hit_timer;
  assign rd_status2 = REG_REQ.rd && hit_status2;

  // Configuration fields.
  logic       alert_on_fan2;
  logic       ot_enable;
  logic       full_speed_on_overtemp_en;
  logic [1:0] multi_role;

  assign alert_on_fan2 = cfg3_q[otat_pkg::CFG3_ALERT_BIT];  // RQ2
  assign ot_enable     = cfg3_q[otat_pkg::CFG3_OTEN_BIT];
  assign full_speed_on_overtemp_en      = cfg3_q[otat_pkg::CFG3_FULL_SPEED_ON_OVERTEMP_BIT];
  assign multi_role    = cfg4_q[otat_pkg::CFG4_ROLE_LSB +: 2];  // RQ3

  // Which pins carry the overtemperature line.
  logic multi_is_ot;
  logic multi_is_alert;
  logic multi_is_tach;
  logic line_asserted;

  assign multi_is_ot    = (multi_role == otat_pkg::ROLE_OVERTEMP);
  assign multi_is_alert = (multi_role == otat_pkg::ROLE_ALERT);
  assign multi_is_tach  = (multi_role == otat_pkg::ROLE_TACH);
  // Monitoring works only once the enable is set; it resets clear.
  assign line_asserted  = ot_enable &&  // RQ4 RQ5
                          (!ded_line_n || (multi_is_ot && !multi_line_n));
  assign VIN25_MEASURE_EN = !ot_enable;  // RQ4

  // Accumulating timer, cleared by a read of its register.
  // A count advances only after a whole tick of assertion; short bursts
  // still add to the partial count held inside the timer.
  otat_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk      (CLK),
    .rst      (RST),
    .asserted (line_asserted),
    .clr      (rd_timer),
    .value_q  (timer_val)
  );

  // Limit compare; a zero limit trips on the first assertion, also after
  // a read taken while the line is held low.
  logic exceeded;

  assign exceeded = (timer_val > limit_q);  // RQ15 RQ16 RQ14

  // Sticky status: the set wins over a read that arrives in the same cycle,
  // and the read only clears once the cause has gone.
  // Otherwise a read racing a new excursion would drop an event that
  // software never saw.
  assign ot_status_d = exceeded ||
                       (ot_status_q && !rd_status2);  // RQ20 RQ1

  // Mask selection follows the pin that carries the line.
  // When the multi-function pin carries it, the second mask register
  // applies; otherwise the bit in the first mask register does.
  logic ot_masked;
  logic alert_active;

  assign ot_masked = multi_is_ot ? mask2_q[otat_pkg::MASK2_OT_BIT]
                                 : mask1_q[otat_pkg::MASK1_OT_BIT];  // RQ17
  // Alert holds while the status bit is set and unmasked.
  assign alert_active = ot_status_q && !ot_masked;  // RQ22 RQ21 RQ1

  // Pin function multiplexing; alert pins are open drain pulled low.
  // In fan-drive role the pin is push-pull, shown as a constant enable;
  // in alert role only the low level is ever driven.
  assign FAN2_PIN_OUT  = alert_on_fan2 ? 1'b0 : FAN_DRIVE_OUTPUT_2;  // RQ2
  assign FAN2_PIN_OE   = alert_on_fan2 ? alert_active : 1'b1;  // RQ22
  assign MULTI_PIN_OUT = 1'b0;
  assign MULTI_PIN_OE  = multi_is_alert && alert_active;  // RQ3 RQ22

  // Tach reading is forwarded only while the pin has that role.
  // The reserved role reads as an idle input.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FAN_SPEED_INPUT_4 <= 1'b1;
    end else begin
      FAN_SPEED_INPUT_4 <= multi_is_tach ? multi_line_n : 1'b1;  // RQ3
    end
  end

  // Full_speed_on_overtemp to full duty for running fans while the line is low.
  // A stopped fan stays stopped, so full_speed_on_overtemp never spins up a fan that
  // software has parked on purpose.
  genvar f;
  generate
    for (f = 0; f < NUM_FANS; f++) begin : g_fan
      logic running;
      logic full_speed_on_overtemp_now;
      assign running   = FAN_IN[f].auto_mode ? FAN_IN[f].above_start
                         : (FAN_IN[f].duty != otat_pkg::DUTY_OFF);  // RQ7
      assign full_speed_on_overtemp_now = full_speed_on_overtemp_en && line_asserted && running;  // RQ6 RQ8
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          FAN_DUTY_OUT[f] <= otat_pkg::DUTY_FULL;
        end else begin
          FAN_DUTY_OUT[f] <= full_speed_on_overtemp_now ? otat_pkg::DUTY_FULL
                                       : FAN_IN[f].duty;  // RQ6 RQ8
        end
      end
    end
  endgenerate

  // Configuration register three; monitoring comes out of reset disabled.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg3_q <= otat_pkg::RST_CFG3;  // RQ5
    end else if (wr_cfg3) begin
      cfg3_q <= REG_REQ.wdata;
    end
  end

  // Configuration register four, holding the multi-function pin role.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg4_q <= otat_pkg::RST_CFG4;
    end else if (wr_cfg4) begin
      cfg4_q <= REG_REQ.wdata;
    end
  end

  // Timer limit register.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      limit_q <= otat_pkg::RST_LIMIT;
    end else if (wr_limit) begin
      limit_q <= REG_REQ.wdata;
    end
  end

  // First interrupt mask register.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mask1_q <= otat_pkg::RST_MASK;
    end else if (wr_mask1) begin
      mask1_q <= REG_REQ.wdata;
    end
  end

  // Second interrupt mask register.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mask2_q <= otat_pkg::RST_MASK;
    end else if (wr_mask2) begin
      mask2_q <= REG_REQ.wdata;
    end
  end

  // Status flag storage.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ot_status_q <= 1'b0;
    end else begin
      ot_status_q <= ot_status_d;  // RQ20
    end
  end

  // Read data selection; unmapped addresses read as zero.
  logic [7:0] rd_mux;
  logic [7:0] status2_view;

  assign status2_view = {2'b00, ot_status_q, 5'b0_0000};
  assign rd_mux =
    hit_cfg3    ? cfg3_q       :
    hit_cfg4    ? cfg4_q       :
    hit_limit   ? limit_q      :
    hit_mask1   ? mask1_q      :
    hit_mask2   ? mask2_q      :
    hit_timer   ? timer_val    :
    hit_status2 ? status2_view : 8'h00;

  // Read answer valid one cycle after the strobe.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_REQ.rd;
    end
  end

  // Read data held until the next read; the timer value is captured
  // before the same edge clears it.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_REQ.rd) begin
      REG_RDATA <= rd_mux;  // RQ11
    end
  end

endmodule

/* core/otat_pkg.sv */
// Constants and carrier types shared by the overtemperature assertion timer.
// Assumes a single 125 MHz clock domain and an upstream serial-bus engine
// that presents decoded one-cycle register reads and writes.
package otat_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_STATUS2 = 8'h42;
  localparam logic [7:0] ADDR_MASK1   = 8'h74;
  localparam logic [7:0] ADDR_MASK2   = 8'h75;
  localparam logic [7:0] ADDR_CFG3    = 8'h78;
  localparam logic [7:0] ADDR_TIMER   = 8'h79;
  localparam logic [7:0] ADDR_LIMIT   = 8'h7a;
  localparam logic [7:0] ADDR_CFG4    = 8'h7d;

  // Field positions.
  localparam int CFG3_ALERT_BIT  = 0;
  localparam int CFG3_OTEN_BIT   = 1;
  localparam int CFG3_FULL_SPEED_ON_OVERTEMP_BIT  = 2;
  localparam int STATUS2_OT_BIT  = 5;
  localparam int MASK1_OT_BIT    = 0;
  localparam int MASK2_OT_BIT    = 5;
  localparam int CFG4_ROLE_LSB   = 0;

  // Roles of the multi-function pin.
  localparam logic [1:0] ROLE_TACH     = 2'h0;
  localparam logic [1:0] ROLE_OVERTEMP = 2'h1;
  localparam logic [1:0] ROLE_ALERT    = 2'h2;

  // Values after reset.
  localparam logic [7:0] RST_CFG3    = 8'h00;
  localparam logic [7:0] RST_CFG4    = 8'h00;
  localparam logic [7:0] RST_LIMIT   = 8'h00;
  localparam logic [7:0] RST_MASK    = 8'h00;
  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [7:0] RST_TIMER   = 8'h00;

  // Timer and fan duty figures.
  localparam logic [7:0] TIMER_FULL  = 8'hff;
  localparam logic [7:0] DUTY_FULL   = 8'hff;
  localparam logic [7:0] DUTY_OFF    = 8'h00;
  localparam real        TICK_PERIOD_MS = 22.76;
  localparam real        CLK_PERIOD_NS  = 8.0;
  localparam int         TICK_CYCLES    =
    int'(TICK_PERIOD_MS * 1.0e6 / CLK_PERIOD_NS);

  // One decoded register access from the serial-bus engine.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } otat_reg_req_s;

  // Settings of one fan as seen by the full_speed_on_overtemp logic.
  typedef struct packed {
    logic       auto_mode;
    logic       above_start;
    logic [7:0] duty;
  } otat_fan_s;

endpackage

/* core/otat_sync.sv */
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are slow levels; no pulse narrower than two clocks.
`timescale 1ns/10ps
module otat_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage; resets to the idle high level.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* core/otat_timer.sv */
// Cumulative saturating assertion timer with clear on read.
// Assumes asserted is synchronous and clr is a one-cycle read strobe.
`timescale 1ns/10ps
module otat_timer #(
  parameter int TICK_CYCLES = otat_pkg::TICK_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       asserted,
  input  wire logic       clr,
  output logic      [7:0] value_q
);

  localparam int SW = $clog2(TICK_CYCLES + 1);
  localparam logic [SW-1:0] SUB_LAST = SW'(TICK_CYCLES - 1);

  logic [SW-1:0] sub_q;
  logic [SW-1:0] sub_d;
  logic [7:0]    tick_q;
  logic [7:0]    tick_d;
  logic          seen_q;
  logic          seen_d;
  logic          sat;
  logic          wrap;
  logic [7:0]    value_d;

  // Counting pauses when the line is released and stops at full scale.
  assign sat  = (tick_q == otat_pkg::TIMER_FULL);
  assign wrap = asserted && !sat && (sub_q == SUB_LAST);
  // A read restarts from zero; an ongoing assertion marks the first bit.
  assign seen_d = clr ? asserted : (seen_q | asserted);  // RQ13
  assign tick_d = clr ? 8'h00 : (wrap ? tick_q + 8'h01 : tick_q);  // RQ10
  assign sub_d  = (clr || wrap) ? '0 :
                  ((asserted && !sat) ? sub_q + SW'(1) : sub_q);  // RQ9
  // Bit 0 shows the first assertion until the second period is reached.
  assign value_d = (tick_d == 8'h00) ? {7'h00, seen_d} : tick_d;  // RQ12

  // Timer state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sub_q   <= '0;
      tick_q  <= otat_pkg::RST_TIMER;
      seen_q  <= 1'b0;
      value_q <= otat_pkg::RST_TIMER;
    end else begin
      sub_q   <= sub_d;
      tick_q  <= tick_d;
      seen_q  <= seen_d;
      value_q <= value_d;  // RQ11
    end
  end

endmodule

/* tb/otat_monitor.sv */
// Port-level assertions for the overtemperature assertion timer.
// Assumes the otat_top port list and a single clock; bound below.
`timescale 1ns/10ps
module otat_monitor #(
  parameter int TICK_CYCLES = otat_pkg::TICK_CYCLES,
  parameter int NUM_FANS    = 3
) (
  input wire logic                            CLK,
  input wire logic                            RST,
  input otat_pkg::otat_reg_req_s              REG_REQ,
  input wire logic                            MULTI_PIN_OUT,
  input wire logic                            MULTI_PIN_OE,
  input wire logic                            FAN2_PIN_OUT,
  input wire logic                            FAN2_PIN_OE,
  input wire logic                            FAN_DRIVE_OUTPUT_2,
  input wire logic                            FAN_SPEED_INPUT_4,
  input wire logic                            VIN25_MEASURE_EN,
  input otat_pkg::otat_fan_s [NUM_FANS-1:0]   FAN_IN,
  input wire logic [NUM_FANS-1:0][7:0]        FAN_DUTY_OUT
);
  // Shadow copies of the pin-function registers, followed from bus writes.
  logic [7:0] cfg3_q;
  logic [7:0] cfg4_q;
  wire        wr_cfg3 = REG_REQ.wr && REG_REQ.addr == otat_pkg::ADDR_CFG3;
  wire        wr_cfg4 = REG_REQ.wr && REG_REQ.addr == otat_pkg::ADDR_CFG4;
  wire        alert_sel = cfg3_q[otat_pkg::CFG3_ALERT_BIT];
  wire        full_speed_on_overtemp_sel = cfg3_q[otat_pkg::CFG3_FULL_SPEED_ON_OVERTEMP_BIT];
  wire [1:0]  role = cfg4_q[1:0];
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg3_q <= otat_pkg::RST_CFG3;
      cfg4_q <= otat_pkg::RST_CFG4;
    end else begin
      if (wr_cfg3)
        cfg3_q <= REG_REQ.wdata;
      if (wr_cfg4)
        cfg4_q <= REG_REQ.wdata;
    end
  end

  // All checks share the one clock and its reset.
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (RST);

  property p_vin25;
    VIN25_MEASURE_EN == !cfg3_q[otat_pkg::CFG3_OTEN_BIT];
  endproperty
  a_vin25: assert property (p_vin25)
    else $error("measurement enable disagrees with overtemp enable");
  property p_fan2_drive;
    !alert_sel |-> FAN2_PIN_OE && FAN2_PIN_OUT == FAN_DRIVE_OUTPUT_2;
  endproperty
  a_fan2_drive: assert property (p_fan2_drive)
    else $error("fan drive pin does not carry the drive level");
  property p_fan2_alert;
    alert_sel |-> !FAN2_PIN_OUT;
  endproperty
  a_fan2_alert: assert property (p_fan2_alert)
    else $error("alert pin drives high");
  property p_multi_role;
    !MULTI_PIN_OUT && (role == otat_pkg::ROLE_ALERT || !MULTI_PIN_OE);
  endproperty
  a_multi_role: assert property (p_multi_role)
    else $error("multi pin pulls low outside alert role");
  property p_tach_role;
    (role != otat_pkg::ROLE_TACH) [*2] |-> FAN_SPEED_INPUT_4;
  endproperty
  a_tach_role: assert property (p_tach_role)
    else $error("tach input follows pin outside tach role");
  property p_full_speed_on_overtemp_off;
    !full_speed_on_overtemp_sel |=> FAN_DUTY_OUT[0] == $past(FAN_IN[0].duty);
  endproperty
  a_full_speed_on_overtemp_off: assert property (p_full_speed_on_overtemp_off)
    else $error("fan duty changed with full_speed_on_overtemp clear");
  property p_full_speed_on_overtemp_idle;
    full_speed_on_overtemp_sel && !FAN_IN[1].auto_mode && FAN_IN[1].duty == 8'h00
      |=> FAN_DUTY_OUT[1] == 8'h00;
  endproperty
  a_full_speed_on_overtemp_idle: assert property (p_full_speed_on_overtemp_idle)
    else $error("stopped fan was boosted");
  property p_alert_release;
    $fell(FAN2_PIN_OE) && $past(alert_sel)
      |-> $past(REG_REQ.rd || REG_REQ.wr);
  endproperty
  a_alert_release: assert property (p_alert_release)
    else $error("alert released without a register access");
endmodule

bind otat_top otat_monitor #(.TICK_CYCLES(TICK_CYCLES), .NUM_FANS(NUM_FANS))
  mon_u (.CLK(CLK), .RST(RST), .REG_REQ(REG_REQ),
    .MULTI_PIN_OUT(MULTI_PIN_OUT), .MULTI_PIN_OE(MULTI_PIN_OE),
    .FAN2_PIN_OUT(FAN2_PIN_OUT), .FAN2_PIN_OE(FAN2_PIN_OE),
    .FAN_DRIVE_OUTPUT_2(FAN_DRIVE_OUTPUT_2),
    .FAN_SPEED_INPUT_4(FAN_SPEED_INPUT_4),
    .VIN25_MEASURE_EN(VIN25_MEASURE_EN), .FAN_IN(FAN_IN),
    .FAN_DUTY_OUT(FAN_DUTY_OUT));

/* tb/otat_hot_src.sv */
// Behavioural overtemperature source: a CPU hot output or trip sensor.
// Assumes the bench raises hold at the falling clock edge.
`timescale 1ns/10ps
module otat_hot_src (
  input  wire logic clk,
  input  wire logic hold,
  input  wire logic slow,
  output logic      line_n
);
  // Open drain with pull-up; a slow source engages and lets go a cycle late.
  logic held_q = 1'b0;
  always @(posedge clk) held_q <= hold;
  assign line_n = !(slow ? held_q : hold);
endmodule

/* tb/overtemp_assertion_timer_alert_tb.sv */
// Self-checking bench for the overtemperature assertion timer top level.
// Assumes a short tick and behavioural line sources on both input pins.
`timescale 1ns/10ps
module overtemp_assertion_timer_alert_tb;
  localparam int TICK = 8;
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      hot_d = 1'b0;
  logic                      hot_m = 1'b0;
  logic                      drv2 = 1'b0;
  otat_pkg::otat_reg_req_s   req = '0;
  otat_pkg::otat_fan_s [2:0] fan_in = '0;
  logic [2:0][7:0]           duty_out;
  logic [7:0]                rdata, exp8;
  logic                      rvalid, oe_m, oe_f, out_m, out_f, spd4, vin25;
  wire                       line_d_n, line_m_n;
  wire                       mpin_n = line_m_n & !oe_m;
  int                        num_errors = 0, total_checks = 0, k;
  int                        seed = 32'he3cf;
  int                        bursts[$];
  logic [7:0]                addrs[8] = '{8'h42, 8'h74, 8'h75, 8'h78,
                                          8'h79, 8'h7a, 8'h7d, 8'h10};

  // Clock, and a random fan drive level changed on the falling edge.
  always #4 clk = ~clk;
  always @(negedge clk) drv2 <= 1'($random(seed));

  otat_hot_src src_d (.clk(clk), .hold(hot_d), .slow(1'b0),
    .line_n(line_d_n));
  otat_hot_src src_m (.clk(clk), .hold(hot_m), .slow(1'b1),
    .line_n(line_m_n));
  otat_top #(.TICK_CYCLES(TICK), .NUM_FANS(3)) dut_u (
    .CLK(clk), .RST(rst), .REG_REQ(req), .REG_RVALID(rvalid),
    .REG_RDATA(rdata), .OVERTEMP_LINE_N_IN(line_d_n),
    .MULTI_PIN_IN(mpin_n), .MULTI_PIN_OUT(out_m), .MULTI_PIN_OE(oe_m),
    .FAN2_PIN_OUT(out_f), .FAN2_PIN_OE(oe_f), .FAN_DRIVE_OUTPUT_2(drv2),
    .FAN_SPEED_INPUT_4(spd4), .VIN25_MEASURE_EN(vin25),
    .FAN_IN(fan_in), .FAN_DUTY_OUT(duty_out));

  // Compares one value and counts the outcome.
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Register write and read, one cycle strobes launched on the falling edge.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    req <= '0;
  endtask
  task automatic rd(logic [7:0] a, string name, logic [7:0] exp);
    @(negedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk);
    req <= '0;
    chk("read valid", 8'h01, {7'h00, rvalid});
    chk(name, exp, rdata);
  endtask

  // Holds one line low for n cycles and records the burst for the model.
  task automatic pulse(int n, bit on_multi);
    @(negedge clk);
    if (on_multi)
      hot_m <= 1'b1;
    else
      hot_d <= 1'b1;
    repeat (n) @(negedge clk);
    hot_m <= 1'b0;
    hot_d <= 1'b0;
    bursts.push_back(n);
    repeat (4) @(negedge clk);
  endtask

  // Timer model: whole ticks of total assertion, at least 1 once any burst is recorded, saturating.
  function automatic logic [7:0] model();
    int t = 0;
    int n = bursts.size();
    foreach (bursts[i])
      t += bursts[i];
    bursts.delete();
    t = t / TICK;
    if (t > 255)
      t = 255;
    return (n == 0) ? 8'h00 : (t == 0) ? 8'h01 : 8'(t);
  endfunction

  // Reset for 12 cycles, then program config three, config four and limit.
  task automatic restart(logic [7:0] c3, logic [7:0] c4, logic [7:0] lim);
    @(negedge clk);
    rst <= 1'b1;
    repeat (12) @(negedge clk);
    rst <= 1'b0;
    bursts.delete();
    wr(8'h78, c3);
    wr(8'h7d, c4);
    wr(8'h7a, lim);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end

  // Main sequence of scenarios.
  initial begin
    restart(8'h00, 8'h00, 8'h00);
    foreach (addrs[i])
      rd(addrs[i], "reset value", 8'h00);
    chk("vin25 enable", 8'h01, {7'h00, vin25});
    pulse(20, 0);
    bursts.delete();
    rd(8'h79, "timer disabled", 8'h00);
    restart(8'h02, 8'h00, 8'hff);
    chk("vin25 enable", 8'h00, {7'h00, vin25});
    pulse(3, 0);
    rd(8'h79, "first assertion", model());
    k = $random(seed) & 7;
    pulse(8 * k + 2, 0);
    k = $random(seed) & 7;
    pulse(8 * k + 3, 0);
    rd(8'h79, "timer total", model());
    wr(8'h79, 8'h55);
    rd(8'h79, "timer cleared", 8'h00);
    pulse(8 * 300 + 4, 0);
    rd(8'h79, "timer saturated", model());
    restart(8'h03, 8'h02, 8'h00);
    chk("alert idle", 8'h00, {6'h00, oe_f, oe_m});
    pulse(3, 0);
    chk("alert pins", 8'h03, {6'h00, oe_f, oe_m});
    rd(8'h42, "status sticky", 8'h20);
    chk("alert held", 8'h03, {6'h00, oe_f, oe_m});
    rd(8'h79, "timer", 8'h01);
    rd(8'h42, "status read", 8'h20);
    rd(8'h42, "status cleared", 8'h00);
    chk("alert released", 8'h00, {6'h00, oe_f, oe_m});
    restart(8'h03, 8'h00, 8'h01);
    pulse(11, 0);
    chk("below limit", 8'h00, {7'h00, oe_f});
    pulse(8, 0);
    chk("above limit", 8'h01, {7'h00, oe_f});
    restart(8'h03, 8'h00, 8'h00);
    wr(8'h74, 8'h01);
    pulse(3, 0);
    chk("masked alert", 8'h00, {7'h00, oe_f});
    rd(8'h42, "masked status", 8'h20);
    wr(8'h74, 8'h00);
    chk("unmasked alert", 8'h01, {7'h00, oe_f});
    restart(8'h03, 8'h01, 8'h00);
    wr(8'h75, 8'h20);
    pulse(3, 1);
    chk("masked multi", 8'h00, {7'h00, oe_f});
    rd(8'h42, "multi status", 8'h20);
    restart(8'h02, 8'h00, 8'h00);
    hot_d <= 1'b1;
    repeat (30) @(negedge clk);
    rd(8'h79, "timer mid", 8'h03);
    rd(8'h79, "timer restarts", 8'h01);
    rd(8'h42, "status on read", 8'h20);
    hot_d <= 1'b0;
    hot_m <= 1'b1;
    repeat (5) @(negedge clk);
    chk("tach follows", 8'h00, {7'h00, spd4});
    wr(8'h7d, 8'h03);
    repeat (2) @(negedge clk);
    chk("reserved role", 8'h01, {7'h00, spd4});
    hot_m <= 1'b0;
    fan_in[0] <= '{1'b0, 1'b0, 8'($random(seed)) | 8'h01};
    fan_in[1] <= '{1'b0, 1'b1, 8'h00};
    fan_in[2] <= '{1'b1, 1'($random(seed)), 8'($random(seed))};
    for (int b = 0; b < 2; b++) begin
      wr(8'h78, b ? 8'h02 : 8'h06);
      hot_d <= 1'b1;
      repeat (6) @(negedge clk);
      foreach (fan_in[i]) begin
        exp8 = (b == 0 && (fan_in[i].auto_mode ? fan_in[i].above_start
               : fan_in[i].duty != 8'h00)) ? 8'hff : fan_in[i].duty;
        chk("fan duty", exp8, duty_out[i]);
      end
      hot_d <= 1'b0;
      repeat (4) @(negedge clk);
    end
    close_out();
  end
endmodule
